// [design/irq_status_pkg.sv]
// Constants for the interrupt status latch bank
package irq_status_pkg;
  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [11:0] OFS_PLL_LANE    = 12'h023;
  localparam logic [11:0] OFS_PRBS_STATUS = 12'h024;
  localparam logic [11:0] OFS_PAIR_A      = 12'h025;
  localparam logic [11:0] OFS_LANE_FULL   = 12'h30C;
  localparam logic [11:0] OFS_LANE_EMPTY  = 12'h30D;
  // ****************************************
  // Field positions, masks and reset value
  // ****************************************
  localparam int BIT_SERDES_LOCK   = 2;
  localparam int BIT_LANE_ERR      = 1;
  localparam int BIT_OVERPOWER     = 7;
  localparam int BIT_BLANKING      = 5;
  localparam int BIT_OSC_ALIGN     = 4;
  localparam int PRBS_LANES        = 4;
  localparam logic [7:0] MASK_PLL_LANE = 8'h06;
  localparam logic [7:0] MASK_PRBS     = 8'h0F;
  localparam logic [7:0] MASK_PAIR_A   = 8'hB0;
  localparam logic [7:0] RESET_STATUS  = 8'h00;
endpackage : irq_status_pkg

// [design/irq_status_latch_bank.sv]
// Interrupt status latch bank with live or sticky status bits
`timescale 1ns/100ps
module irq_status_latch_bank #(
  parameter int LANES = 8
) (
  input  wire logic             mclk,
  input  wire logic             rst_n,
  input  wire logic             reg_wr,
  input  wire logic             reg_rd,
  input  wire logic [11:0]      reg_addr,
  input  wire logic [7:0]       reg_wdata,
  output logic      [7:0]       reg_rdata,
  output logic                  irq_n,
  input  wire logic             serdes_pll_locked_flag,
  input  wire logic [LANES-1:0] lane_full,
  input  wire logic [LANES-1:0] lane_empty,
  input  wire logic             link_enable,
  input  wire logic             chan3_pattern_error_flag,
  input  wire logic             chan2_pattern_error_flag,
  input  wire logic             chan1_pattern_error_flag,
  input  wire logic             chan0_pattern_error_flag,
  input  wire logic             pair_a_overpower_flag,
  input  wire logic             pair_a_blanking_complete_flag,
  input  wire logic             pair_a_oscillator_align_flag,
  input  wire logic             sticky_en_serdes_lock,
  input  wire logic             sticky_en_lane_buffer,
  input  wire logic             sticky_en_chan3_pattern,
  input  wire logic             sticky_en_chan2_pattern,
  input  wire logic             sticky_en_chan1_pattern,
  input  wire logic             sticky_en_chan0_pattern,
  input  wire logic             sticky_en_pair_a_overpower,
  input  wire logic             sticky_en_pair_a_blanking,
  input  wire logic             sticky_en_pair_a_osc_align
);
  localparam int NSRC = 9;

  // ****************************************
  // Input synchronisers
  // ****************************************
  // Conditions arrive from other logic blocks on other clocks, so all pass two flops
  logic [NSRC-1:0]      raw_cond;
  logic [NSRC-1:0]      sticky_en;
  logic [NSRC-1:0]      cond_s1;
  logic [NSRC-1:0]      cond;
  logic [NSRC-1:0]      cond_prev;
  logic [LANES-1:0]     full_s1;
  logic [LANES-1:0]     full_s;
  logic [LANES-1:0]     empty_s1;
  logic [LANES-1:0]     empty_s;
  logic                 link_s1;
  logic                 link_s;
  logic                 link_prev;
  logic                 lane_err_hold;
  logic [NSRC-1:0]      latched;
  logic [NSRC-1:0]      clear_req;
  logic [NSRC-1:0]      view;

  // Source index: 0 pll lock, 1 lane error, 2..5 chan0..3, 6 osc align, 7 blanking, 8 overpower
  assign raw_cond = {pair_a_overpower_flag, pair_a_blanking_complete_flag, pair_a_oscillator_align_flag,
                     chan3_pattern_error_flag, chan2_pattern_error_flag, chan1_pattern_error_flag,
                     chan0_pattern_error_flag, lane_err_hold, serdes_pll_locked_flag};
  assign sticky_en = {sticky_en_pair_a_overpower, sticky_en_pair_a_blanking, sticky_en_pair_a_osc_align,
                      sticky_en_chan3_pattern, sticky_en_chan2_pattern, sticky_en_chan1_pattern,
                      sticky_en_chan0_pattern, sticky_en_lane_buffer, sticky_en_serdes_lock};

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      full_s1  <= '0;
      full_s   <= '0;
      empty_s1 <= '0;
      empty_s  <= '0;
      link_s1  <= 1'b0;
      link_s   <= 1'b0;
    end else begin
      full_s1  <= lane_full;
      full_s   <= full_s1;
      empty_s1 <= lane_empty;
      empty_s  <= empty_s1;
      link_s1  <= link_enable;
      link_s   <= link_s1;
    end
  end

  // ****************************************
  // Lane buffer error hold
  // ****************************************
  // Error survives until the link is taken down and brought back up
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      link_prev     <= 1'b0;
      lane_err_hold <= 1'b0;
    end else begin
      link_prev <= link_s;
      if (link_s && (|full_s || |empty_s)) begin
        lane_err_hold <= 1'b1;
      end else if (link_s && !link_prev) begin
        lane_err_hold <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      cond_s1   <= '0;
      cond      <= '0;
      cond_prev <= '0;
    end else begin
      cond_s1   <= raw_cond;
      cond      <= cond_s1;
      cond_prev <= cond;
    end
  end

  // ****************************************
  // Write-one-to-clear decode
  // ****************************************
  always_comb begin
    clear_req = '0;
    if (reg_wr && reg_addr == irq_status_pkg::OFS_PLL_LANE) begin
      clear_req[0] = reg_wdata[irq_status_pkg::BIT_SERDES_LOCK];
      clear_req[1] = reg_wdata[irq_status_pkg::BIT_LANE_ERR];
    end else if (reg_wr && reg_addr == irq_status_pkg::OFS_PRBS_STATUS) begin
      clear_req[5:2] = reg_wdata[irq_status_pkg::PRBS_LANES-1:0];
    end else if (reg_wr && reg_addr == irq_status_pkg::OFS_PAIR_A) begin
      clear_req[6] = reg_wdata[irq_status_pkg::BIT_OSC_ALIGN];
      clear_req[7] = reg_wdata[irq_status_pkg::BIT_BLANKING];
      clear_req[8] = reg_wdata[irq_status_pkg::BIT_OVERPOWER];
    end
  end

  // ****************************************
  // Sticky latches
  // ****************************************
  // A rising edge in the same cycle as a clear wins, so no event is lost
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      latched <= '0;
    end else begin
      for (int i = 0; i < NSRC; i++) begin
        if (!sticky_en[i]) begin
          latched[i] <= 1'b0;
        end else if (cond[i] && !cond_prev[i]) begin
          latched[i] <= 1'b1;
        end else if (clear_req[i] || (i == 1 && link_s && !link_prev)) begin
          latched[i] <= 1'b0;
        end
      end
    end
  end

  always_comb begin
    for (int i = 0; i < NSRC; i++) begin
      view[i] = sticky_en[i] ? latched[i] : cond[i];
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      irq_n <= 1'b1;
    end else begin
      irq_n <= ~(|(latched & sticky_en));
    end
  end

  // ****************************************
  // Read data
  // ****************************************
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      reg_rdata <= irq_status_pkg::RESET_STATUS;
    end else if (reg_rd) begin
      if (reg_addr == irq_status_pkg::OFS_PLL_LANE) begin
        reg_rdata <= {5'h00, view[0], view[1], 1'b0};
      end else if (reg_addr == irq_status_pkg::OFS_PRBS_STATUS) begin
        reg_rdata <= {4'h0, view[5:2]};
      end else if (reg_addr == irq_status_pkg::OFS_PAIR_A) begin
        reg_rdata <= {view[8], 1'b0, view[7], view[6], 4'h0};
      end else if (reg_addr == irq_status_pkg::OFS_LANE_FULL) begin
        reg_rdata <= 8'(full_s);
      end else if (reg_addr == irq_status_pkg::OFS_LANE_EMPTY) begin
        reg_rdata <= 8'(empty_s);
      end else begin
        reg_rdata <= 8'h00;
      end
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  sequence s_rise(int k);
    cond[k] && !cond_prev[k];
  endsequence

  a_sticky_sets_irq: assert property (@(posedge mclk) disable iff (!rst_n)
    ((sticky_en_chan0_pattern && $past(sticky_en_chan0_pattern)) and s_rise(2)) |=> latched[2] ##1 !irq_n)
    else $error("sticky rise did not latch and raise irq");
  a_irq_held: assert property (@(posedge mclk) disable iff (!rst_n)
    (|(latched & sticky_en)) |=> !irq_n)
    else $error("irq released while bit latched");
  a_irq_idle: assert property (@(posedge mclk) disable iff (!rst_n)
    !(|(latched & sticky_en)) |=> irq_n)
    else $error("irq asserted with nothing latched");
  a_no_selfclear: assert property (@(posedge mclk) disable iff (!rst_n)
    (latched[3] && sticky_en[3] && !clear_req[3] && $stable(sticky_en[3])) |=> latched[3])
    else $error("latched bit cleared itself");
  a_w1c_clears: assert property (@(posedge mclk) disable iff (!rst_n)
    (latched[4] && clear_req[4] && !(cond[4] && !cond_prev[4])) |=> !latched[4])
    else $error("write one did not clear");
  a_live_view: assert property (@(posedge mclk) disable iff (!rst_n)
    (reg_rd && reg_addr == irq_status_pkg::OFS_PRBS_STATUS && !sticky_en_chan1_pattern)
      |=> reg_rdata[1] == $past(cond[3]))
    else $error("live read mismatch");
  a_reserved_zero: assert property (@(posedge mclk) disable iff (!rst_n)
    (reg_addr == irq_status_pkg::OFS_PAIR_A && reg_rd) |=> (reg_rdata & ~irq_status_pkg::MASK_PAIR_A) == 8'h00)
    else $error("reserved bits nonzero");
  a_lane_err_set: assert property (@(posedge mclk) disable iff (!rst_n)
    (link_s && |full_s) |=> lane_err_hold)
    else $error("lane buffer error not flagged");
  a_lane_err_keep: assert property (@(posedge mclk) disable iff (!rst_n)
    (lane_err_hold && !(link_s && !link_prev)) |=> lane_err_hold)
    else $error("lane buffer error dropped without re-enable");

  // ****************************************
  // Read path assertions
  // ****************************************
  // Read data lands one cycle after the strobe, so expectations use $past
  sequence s_read(logic [11:0] a);
    reg_rd && reg_addr == a;
  endsequence

  a_live_pll: assert property (@(posedge mclk) disable iff (!rst_n)
    (s_read(irq_status_pkg::OFS_PLL_LANE) and !sticky_en_serdes_lock)
      |=> reg_rdata[irq_status_pkg::BIT_SERDES_LOCK] == $past(cond[0]))
    else $error("pll lock read mismatch");
  a_lane_err_read: assert property (@(posedge mclk) disable iff (!rst_n)
    (s_read(irq_status_pkg::OFS_PLL_LANE) and !sticky_en_lane_buffer)
      |=> reg_rdata[irq_status_pkg::BIT_LANE_ERR] == $past(lane_err_hold))
    else $error("lane buffer error read mismatch");
  a_pll_reserved: assert property (@(posedge mclk) disable iff (!rst_n)
    s_read(irq_status_pkg::OFS_PLL_LANE)
      |=> (reg_rdata & ~irq_status_pkg::MASK_PLL_LANE) == 8'h00)
    else $error("pll lane reserved bits nonzero");
  a_full_read: assert property (@(posedge mclk) disable iff (!rst_n)
    s_read(irq_status_pkg::OFS_LANE_FULL)
      |=> reg_rdata == 8'($past(full_s)))
    else $error("lane full read mismatch");
  a_empty_read: assert property (@(posedge mclk) disable iff (!rst_n)
    s_read(irq_status_pkg::OFS_LANE_EMPTY)
      |=> reg_rdata == 8'($past(empty_s)))
    else $error("lane empty read mismatch");
  a_prbs_reserved: assert property (@(posedge mclk) disable iff (!rst_n)
    s_read(irq_status_pkg::OFS_PRBS_STATUS)
      |=> (reg_rdata & ~irq_status_pkg::MASK_PRBS) == 8'h00)
    else $error("pattern register reserved bits nonzero");
  a_overpower_read: assert property (@(posedge mclk) disable iff (!rst_n)
    (s_read(irq_status_pkg::OFS_PAIR_A) and !sticky_en_pair_a_overpower)
      |=> reg_rdata[irq_status_pkg::BIT_OVERPOWER] == $past(cond[8]))
    else $error("overpower read mismatch");
  a_blanking_read: assert property (@(posedge mclk) disable iff (!rst_n)
    (s_read(irq_status_pkg::OFS_PAIR_A) and !sticky_en_pair_a_blanking)
      |=> reg_rdata[irq_status_pkg::BIT_BLANKING] == $past(cond[7]))
    else $error("blanking read mismatch");
  a_osc_read: assert property (@(posedge mclk) disable iff (!rst_n)
    (s_read(irq_status_pkg::OFS_PAIR_A) and !sticky_en_pair_a_osc_align)
      |=> reg_rdata[irq_status_pkg::BIT_OSC_ALIGN] == $past(cond[6]))
    else $error("oscillator align read mismatch");

  // ****************************************
  // Latch behaviour assertions
  // ****************************************
  a_rise_wins: assert property (@(posedge mclk) disable iff (!rst_n)
    (sticky_en[4] and s_rise(4))
      |=> latched[4])
    else $error("rising edge lost against clear");
  a_sticky_off: assert property (@(posedge mclk) disable iff (!rst_n)
    !sticky_en[2]
      |=> !latched[2])
    else $error("latch kept while in live mode");
  a_zero_write_keeps: assert property (@(posedge mclk) disable iff (!rst_n)
    (latched[5] && sticky_en[5] && reg_wr && reg_addr == irq_status_pkg::OFS_PRBS_STATUS && !reg_wdata[3])
      |=> latched[5])
    else $error("zero write cleared a latched bit");
  a_w1c_overpower: assert property (@(posedge mclk) disable iff (!rst_n)
    (latched[8] && clear_req[8] && !(cond[8] && !cond_prev[8]))
      |=> !latched[8])
    else $error("write one did not clear overpower");
  a_lane_err_clear: assert property (@(posedge mclk) disable iff (!rst_n)
    (lane_err_hold && link_s && !link_prev && !(|full_s || |empty_s))
      |=> !lane_err_hold)
    else $error("link re-enable did not clear lane buffer error");
endmodule : irq_status_latch_bank

// [sim/tb_top.sv]
// Self-checking testbench for the interrupt status latch bank
`timescale 1ns/100ps
module tb_top;
  logic       mclk = 1'b0;
  logic       rst_n = 1'b0;
  logic       reg_wr = 1'b0;
  logic       reg_rd = 1'b0;
  logic [11:0] reg_addr = 12'h000;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] reg_rdata;
  logic       irq_n;
  logic       pll = 1'b0;
  logic       link_en = 1'b0;
  logic [7:0] full = 8'h00;
  logic [7:0] empty = 8'h00;
  logic [6:0] cond = 7'h00;
  logic [6:0] sticky = 7'h00;
  logic       sticky_pll = 1'b0;
  logic [7:0] v;
  logic [6:0] r;
  int         errors = 0;
  int         checks_done = 0;

  always #25 mclk = ~mclk;

  irq_status_latch_bank #(.LANES(8)) DUT (
    .mclk(mclk), .rst_n(rst_n), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .irq_n(irq_n), .serdes_pll_locked_flag(pll),
    .lane_full(full), .lane_empty(empty), .link_enable(link_en),
    .chan3_pattern_error_flag(cond[3]), .chan2_pattern_error_flag(cond[2]),
    .chan1_pattern_error_flag(cond[1]), .chan0_pattern_error_flag(cond[0]),
    .pair_a_overpower_flag(cond[4]), .pair_a_blanking_complete_flag(cond[5]),
    .pair_a_oscillator_align_flag(cond[6]), .sticky_en_serdes_lock(sticky_pll),
    .sticky_en_lane_buffer(1'b0), .sticky_en_chan3_pattern(sticky[3]),
    .sticky_en_chan2_pattern(sticky[2]), .sticky_en_chan1_pattern(sticky[1]),
    .sticky_en_chan0_pattern(sticky[0]), .sticky_en_pair_a_overpower(sticky[4]),
    .sticky_en_pair_a_blanking(sticky[5]), .sticky_en_pair_a_osc_align(sticky[6])
  );

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [7:0] exp_prbs(input logic [6:0] c);
    return {4'h0, c[3:0]};
  endfunction : exp_prbs

  function automatic logic [7:0] exp_pair(input logic [6:0] c);
    return {c[4], 1'b0, c[5], c[6], 4'h0};
  endfunction : exp_pair

  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : tick

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // Each access ends one idle cycle later so strobes never toggle twice in a step
  task automatic rd(input logic [11:0] a, output logic [7:0] d);
    reg_addr = a;
    reg_rd = 1'b1;
    tick(1);
    reg_rd = 1'b0;
    d = reg_rdata;
    tick(1);
  endtask : rd

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    tick(1);
    reg_wr = 1'b0;
    tick(1);
  endtask : wr

  task automatic end_of_test;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : end_of_test

  initial begin
    repeat (20000) @(posedge mclk);
    errors++;
    end_of_test;
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    void'($urandom(55));
    tick(5);
    rst_n = 1'b1;
    chk({7'h00, irq_n}, 8'h01);
    rd(irq_status_pkg::OFS_PLL_LANE, v); chk(v, 8'h00);
    rd(irq_status_pkg::OFS_PRBS_STATUS, v); chk(v, 8'h00);
    rd(irq_status_pkg::OFS_PAIR_A, v); chk(v, 8'h00);
    // Live mode with random levels, link held off so no lane error
    repeat (8) begin
      cond = 7'($urandom);
      pll = 1'($urandom);
      full = 8'($urandom);
      empty = 8'($urandom);
      tick(5);
      rd(irq_status_pkg::OFS_PRBS_STATUS, v); chk(v, exp_prbs(cond));
      rd(irq_status_pkg::OFS_PAIR_A, v); chk(v, exp_pair(cond));
      rd(irq_status_pkg::OFS_PLL_LANE, v); chk(v, {5'h00, pll, 2'b00});
      rd(irq_status_pkg::OFS_LANE_FULL, v); chk(v, full);
      rd(irq_status_pkg::OFS_LANE_EMPTY, v); chk(v, empty);
      chk({7'h00, irq_n}, 8'h01);
    end
    // Lane buffer error holds until the link is cycled
    full = 8'h00;
    empty = 8'h00;
    pll = 1'b0;
    link_en = 1'b1;
    tick(5);
    full = 8'h80;
    tick(5);
    rd(irq_status_pkg::OFS_PLL_LANE, v); chk(v, 8'h02);
    full = 8'h00;
    tick(5);
    wr(irq_status_pkg::OFS_PLL_LANE, 8'h02);
    rd(irq_status_pkg::OFS_PLL_LANE, v); chk(v, 8'h02);
    link_en = 1'b0;
    tick(3);
    link_en = 1'b1;
    tick(5);
    rd(irq_status_pkg::OFS_PLL_LANE, v); chk(v, 8'h00);
    // Sticky mode: latch, survive a fall and a zero write, clear by one
    cond = 7'h00;
    sticky = 7'h7F;
    sticky_pll = 1'b1;
    tick(5);
    r = 7'($urandom) | 7'h11;
    cond = r;
    pll = 1'b1;
    tick(5);
    chk({7'h00, irq_n}, 8'h00);
    cond = 7'h00;
    pll = 1'b0;
    tick(5);
    rd(irq_status_pkg::OFS_PRBS_STATUS, v); chk(v, exp_prbs(r));
    rd(irq_status_pkg::OFS_PLL_LANE, v); chk(v, 8'h04);
    wr(irq_status_pkg::OFS_PRBS_STATUS, 8'h00);
    wr(12'h100, 8'hFF);
    rd(12'h100, v); chk(v, 8'h00);
    rd(irq_status_pkg::OFS_PRBS_STATUS, v); chk(v, exp_prbs(r));
    wr(irq_status_pkg::OFS_PRBS_STATUS, 8'hFF);
    wr(irq_status_pkg::OFS_PLL_LANE, 8'h04);
    rd(irq_status_pkg::OFS_PRBS_STATUS, v); chk(v, 8'h00);
    rd(irq_status_pkg::OFS_PLL_LANE, v); chk(v, 8'h00);
    chk({7'h00, irq_n}, 8'h00);
    rd(irq_status_pkg::OFS_PAIR_A, v); chk(v, exp_pair(r));
    wr(irq_status_pkg::OFS_PAIR_A, 8'hFF);
    tick(2);
    rd(irq_status_pkg::OFS_PAIR_A, v); chk(v, 8'h00);
    chk({7'h00, irq_n}, 8'h01);
    end_of_test;
  end
endmodule : tb_top
